// File: tb_top.sv
// self-checking bench for the terminal decoder and its switch model
// assumes term_decode_pkg, term_decode and term_switch_model are compiled
`timescale 1ns/1ns

`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  n_fail++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end

module tb_top;
  int          seed = 32'ha884;
  int          n_fail = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        ce = 1'b1;
  logic        wr_s = 1'b0;
  logic        rd_s = 1'b0;
  logic [7:0]  sw = 8'h00;
  logic [1:0]  cur = 2'h0;
  logic [10:0] v0 = 11'h000;
  logic [10:0] v1 = 11'h000;
  logic [5:0]  addr = 6'h00;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata, as0, as1;
  logic [19:0] freq;
  logic [10:0] ain0, ain1;
  logic [7:0]  din, filt;
  logic [1:0]  msel;
  logic        ain_v, run, reverse_run_request;
  logic [5:0]  ra [9] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h08, 6'h0a, 6'h0b,
                          6'h0c, 6'h3f};
  logic [15:0] rv [9] = '{16'h000a, 16'h0000, 16'h0064, 16'h0001, 16'h0000,
                          16'h03e8, 16'h2710, 16'h000a, 16'h0000};
  logic [7:0]  seq [5] = '{8'h04, 8'h05, 8'h04, 8'h06, 8'h02};
  logic [1:0]  sexp [5] = '{2'h0, 2'h1, 2'h1, 2'h3, 2'h0};
  logic [15:0] ures [3] = '{16'h0002, 16'h0001, 16'h0001};
  logic [15:0] urate [3] = '{16'h1388, 16'h01f4, 16'h01f4};
  logic [7:0]  usw [3] = '{8'h40, 8'h40, 8'h80};
  int          udelta [3] = '{100, 100, -100};
  int          corner [4] = '{200, 700, 199, 1000};

  always #2 clk_i = ~clk_i;

  term_decode #(.N_IN(8), .MS_CYCLES(10)) i_term_decode (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce), .din_i(din),
    .ain0_i(ain0), .ain1_i(ain1), .ain_valid_i(ain_v), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr_s), .rd_i(rd_s), .rdata_o(rdata),
    .run_o(run), .reverse_o(reverse_run_request), .motor_sel_o(msel), .freq_ref_o(freq),
    .analog_set0_o(as0), .analog_set1_o(as1), .din_filt_o(filt));

  term_switch_model i_term_switch_model (
    .clk_i(clk_i), .sw_i(sw), .volt0_i(v0), .volt1_i(v1), .cur_i(cur),
    .din_o(din), .ain0_o(ain0), .ain1_o(ain1), .ain_valid_o(ain_v));

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    tick(1);
    wr_s  <= 1'b0;
    tick(1);
  endtask

  task automatic rd(input logic [5:0] a, output logic [15:0] d);
    addr <= a;
    rd_s <= 1'b1;
    tick(1);
    rd_s <= 1'b0;
    tick(1);
    d = rdata;
  endtask

  task automatic summarize();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // {reverse, run} of the two-line schemes
  function automatic logic [1:0] exp2(input int s, input logic [1:0] x);
    if (s == 1) return {x[0] & x[1], x[0]};
    return (x[0] ^ x[1]) ? {x[1], 1'b1} : 2'b00;
  endfunction

  function automatic logic [15:0] curve(input int x, lo, hi, sl, sb);
    if (x < lo) return 16'(sb);
    if (x > hi) return 16'h2710;
    return 16'(sl + (x - lo) * (10000 - sl) / (hi - lo));
  endfunction

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end

  initial begin
    logic [15:0] v;
    int          x, d, f0;
    tick(10);
    sys_rst_i <= 1'b0;
    tick(1);
    foreach (ra[i]) begin
      rd(ra[i], v);
      `CHK(v, rv[i])
    end
    wr(6'h00, 16'h07d0);
    rd(6'h00, v);
    `CHK(v, 16'h03e8)
    // a short glitch is dropped, a held level passes after 2 ms
    wr(6'h00, 16'h0002);
    sw <= 8'h08;
    tick(5);
    sw <= 8'h00;
    tick(40);
    `CHK(filt[3], 1'b0)
    sw <= 8'h08;
    tick(8);
    `CHK(filt[3], 1'b0)
    tick(30);
    `CHK(filt[3], 1'b1)
    wr(6'h00, 16'h0000);
    wr(6'h24, {10'h000, term_decode_pkg::FN_MSEL1});
    wr(6'h25, {10'h000, term_decode_pkg::FN_MSEL2});
    for (int k = 0; k < 4; k++) begin
      sw <= 8'(k << 4);
      tick(8);
      `CHK(msel, 2'(k))
    end
    rd(6'h05, v);
    `CHK(v, 16'h300c)
    for (int s = 0; s < 4; s++) begin
      wr(6'h01, 16'(s));
      rd(6'h01, v);
      `CHK(v, 16'(s))
      for (int i = 0; i < 8 && s < 2; i++) begin
        x = $random(seed);
        sw <= 8'(x & 3);
        tick(8);
        `CHK({reverse_run_request & run, run}, exp2(s, 2'(x)))
      end
      for (int i = 0; i < 5 && s > 1; i++) begin
        sw <= seq[i];
        tick(8);
        `CHK({reverse_run_request & run, run}, sexp[i])
      end
    end
    wr(6'h26, {10'h000, term_decode_pkg::FN_UP});
    wr(6'h27, {10'h000, term_decode_pkg::FN_DOWN});
    for (int i = 0; i < 3; i++) begin
      wr(6'h03, ures[i]);
      wr(6'h02, urate[i]);
      rd(6'h06, v);
      f0 = v;
      sw <= usw[i];
      tick(200);
      sw <= 8'h00;
      tick(8);
      rd(6'h06, v);
      d = int'(v) - f0 - udelta[i];
      `CHK(d inside {[-4:4]}, 1'b1)
      `CHK(freq, 20'(v))
    end
    wr(6'h0c, 16'h0000);
    wr(6'h0a, 16'h02bc);
    wr(6'h08, 16'h00c8);
    wr(6'h0d, 16'hec78);
    wr(6'h14, 16'h0000);
    wr(6'h12, 16'h044c);
    rd(6'h12, v);
    `CHK(v, 16'h03e8)
    wr(6'h10, 16'h07d0);
    rd(6'h10, v);
    `CHK(v, 16'h03e8)
    wr(6'h10, 16'h0000);
    wr(6'h11, 16'hc000);
    rd(6'h11, v);
    `CHK(v, 16'hd8f0)
    for (int i = 0; i < 16; i++) begin
      x = (i < 4) ? corner[i] : $unsigned($random(seed)) % 1001;
      cur <= 2'(i);
      wr(6'h04, 16'(i & 3));
      v0 <= 11'(x);
      v1 <= 11'(x);
      tick(30);
      `CHK(as0, curve(x, 200, 700, 0, -5000))
      `CHK(as1, curve(x, 0, 1000, -10000, 0))
    end
    // a write while the enable is low must leave the scheme untouched
    ce <= 1'b0;
    wr(6'h01, 16'h0000);
    ce <= 1'b1;
    rd(6'h01, v);
    `CHK(v, 16'h0003)
    summarize();
  end
endmodule

// File: term_decode.sv
// drive terminal input decoder: debounce, run/direction schemes, motor
// select, up/down frequency pacing and two analog curve channels
// assumes raw terminals are asynchronous; analog samples and the register
// port share clk_i
// Functional notes
// - two select bits pick parameter set one to four
// - debounce terminals, 0 to 1 s, default 10 ms
// - command scheme 0 to 3, reset 0
// - scheme 0: first forward, second reverse
// - scheme 1: first runs, second sets direction
// - scheme 2: enabled presses start forward or reverse
// - three-line: enable low stops at once
// - three-line: presses latched, latest action wins
// - scheme 3: press starts, second level sets direction
// - up/down rate programmable, default 1 Hz/s
// - resolution code scales up/down rate
// - first analog curve: min/max points, signed settings
// - curve minimum never above curve maximum
// - above maximum input use maximum setting
// - below minimum input use below-minimum setting
// - current input: 1 mA equals 0.5 V
// - analog filter 0 to 10 s, default 0.1 s
// - second analog channel identical, own parameters
// - function codes 41/42 assign motor select bits
//
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/1ns

module term_decode #(
  parameter int N_IN      = 8,
  parameter int MS_CYCLES = term_decode_pkg::MS_CYCLES
) (
  // clock, reset, enable
  input  wire logic              clk_i,
  input  wire logic              sys_rst_i,
  input  wire logic              ce_i,
  // raw terminals and analog samples
  input  wire logic [N_IN-1:0]   din_i,
  input  wire logic [10:0]       ain0_i,
  input  wire logic [10:0]       ain1_i,
  input  wire logic              ain_valid_i,
  // register port
  input  wire logic [5:0]        addr_i,
  input  wire logic [15:0]       wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [15:0]       rdata_o,
  // decoded commands
  output logic                   run_o,
  output logic                   reverse_o,
  output logic      [1:0]        motor_sel_o,
  output logic      [19:0]       freq_ref_o,
  output logic      [15:0]       analog_set0_o,
  output logic      [15:0]       analog_set1_o,
  output logic      [N_IN-1:0]   din_filt_o
);

  localparam logic [27:0] CLK_HZ = 28'(1000 * MS_CYCLES);
  localparam logic [19:0] MS_LAST = 20'(MS_CYCLES - 1);

  typedef struct packed {
    logic [N_IN-1:0]       sync1;
    logic [N_IN-1:0]       sync2;
    logic [N_IN-1:0]       filt;
    logic [N_IN-1:0]       filt_d;
    logic [N_IN-1:0][9:0]  cnt;
    logic [N_IN-1:0][5:0]  fcode;
    logic [19:0]           ms_cnt;
    logic                  ms_tick;
    logic [9:0]            dfilt;
    logic [1:0]            scheme;
    logic [15:0]           rate;
    logic [1:0]            res;
    logic [1:0]            cur_mode;
    logic [1:0][9:0]       xmin;
    logic [1:0][9:0]       xmax;
    logic [1:0][9:0]       afilt;
    logic [1:0][15:0]      smin;
    logic [1:0][15:0]      smax;
    logic [1:0][15:0]      sbelow;
    logic [1:0][10:0]      ain;
    logic [1:0][15:0]      aset;
    logic                  run;
    logic                  reverse_run_request;
    logic [1:0]            msel;
    logic [27:0]           phase;
    logic [19:0]           freq;
    logic [15:0]           rdata;
  } state_t;

  state_t s_reg;
  state_t s_next;

  // per-terminal function hits
  logic [N_IN-1:0] hit_up;
  logic [N_IN-1:0] hit_down;
  logic [N_IN-1:0] hit_m1;
  logic [N_IN-1:0] hit_m2;
  logic [N_IN-1:0] rise;
  logic [1:0]      sel_bits;

  genvar gi;
  generate
    for (gi = 0; gi < N_IN; gi++) begin : g_fn
      assign hit_up[gi]   = s_reg.filt[gi] &
                            (s_reg.fcode[gi] == term_decode_pkg::FN_UP);
      assign hit_down[gi] = s_reg.filt[gi] &
                            (s_reg.fcode[gi] == term_decode_pkg::FN_DOWN);
      assign hit_m1[gi]   = s_reg.filt[gi] &
                            (s_reg.fcode[gi] == term_decode_pkg::FN_MSEL1);
      assign hit_m2[gi]   = s_reg.filt[gi] &
                            (s_reg.fcode[gi] == term_decode_pkg::FN_MSEL2);
      assign rise[gi]     = s_reg.filt[gi] & ~s_reg.filt_d[gi];
    end
  endgenerate

  assign sel_bits = {|hit_m2, |hit_m1};

  // clamp a signed setting into the legal percentage span
  function automatic logic [15:0] clamp_set(input logic [15:0] v);
    logic signed [15:0] sv;
    sv = v;
    if (sv > $signed(term_decode_pkg::SET_POS_MAX))
      clamp_set = term_decode_pkg::SET_POS_MAX;
    else if (sv < $signed(term_decode_pkg::SET_NEG_MAX))
      clamp_set = term_decode_pkg::SET_NEG_MAX;
    else
      clamp_set = v;
  endfunction

  always_comb begin
    logic               f0;
    logic               f1;
    logic               f2;
    logic [19:0]        step;
    logic [27:0]        ph;
    logic               up;
    logic               dn;
    logic signed [16:0] dspan;
    logic signed [11:0] xoff;
    logic signed [11:0] xspan;
    logic signed [29:0] prod;
    logic signed [16:0] target;
    logic signed [16:0] diff;
    logic signed [16:0] dstep;
    logic signed [14:0] tms;
    logic [2:0]         bank;
    logic [2:0]         ofs;
    f0     = s_reg.filt[0];
    f1     = s_reg.filt[1];
    f2     = s_reg.filt[2];
    step   = '0;
    ph     = '0;
    up     = 1'b0;
    dn     = 1'b0;
    dspan  = '0;
    xoff   = '0;
    xspan  = '0;
    prod   = '0;
    target = '0;
    diff   = '0;
    dstep  = '0;
    tms    = '0;
    bank   = addr_i[5:3];
    ofs    = addr_i[2:0];
    s_next = s_reg;
    if (sys_rst_i) begin
      s_next        = '0;
      s_next.dfilt  = term_decode_pkg::DFILT_RST;
      s_next.scheme = term_decode_pkg::SCHEME_RST;
      s_next.rate   = term_decode_pkg::RATE_RST;
      s_next.res    = term_decode_pkg::RES_RST;
      for (int c = 0; c < 2; c++) begin
        s_next.xmin[c]   = term_decode_pkg::XMIN_RST;
        s_next.xmax[c]   = term_decode_pkg::XMAX_RST;
        s_next.smin[c]   = term_decode_pkg::SMIN_RST;
        s_next.smax[c]   = term_decode_pkg::SMAX_RST;
        s_next.sbelow[c] = term_decode_pkg::SBELOW_RST;
        s_next.afilt[c]  = term_decode_pkg::AFILT_RST;
      end
    end else begin
      // millisecond time base
      s_next.ms_tick = (s_reg.ms_cnt == MS_LAST);
      s_next.ms_cnt  = s_next.ms_tick ? '0 : s_reg.ms_cnt + 20'h00001;

      // terminal debounce
      s_next.sync1  = din_i;
      s_next.sync2  = s_reg.sync1;
      s_next.filt_d = s_reg.filt;
      for (int i = 0; i < N_IN; i++) begin
        if (s_reg.sync2[i] == s_reg.filt[i]) begin
          s_next.cnt[i] = '0;
        end else if (s_reg.cnt[i] >= s_reg.dfilt) begin
          s_next.filt[i] = s_reg.sync2[i];
          s_next.cnt[i]  = '0;
        end else if (s_reg.ms_tick) begin
          s_next.cnt[i] = s_reg.cnt[i] + 10'h001;
        end
      end

      // run and direction decode
      case (s_reg.scheme)
        2'h0: begin
          s_next.run = f0 ^ f1;
          s_next.reverse_run_request = f1 & ~f0;
        end
        2'h1: begin
          s_next.run = f0;
          s_next.reverse_run_request = f1;
        end
        2'h2: begin
          if (!f2) begin
            s_next.run = 1'b0;
          end else if (rise[0]) begin
            s_next.run = 1'b1;
            s_next.reverse_run_request = 1'b0;
          end else if (rise[1]) begin
            s_next.run = 1'b1;
            s_next.reverse_run_request = 1'b1;
          end
        end
        default: begin
          if (!f2)
            s_next.run = 1'b0;
          else if (rise[0])
            s_next.run = 1'b1;
          s_next.reverse_run_request = f1;
        end
      endcase

      s_next.msel = sel_bits;

      // up/down pacing, one milli-hertz per overflow of the phase
      step = (s_reg.res == term_decode_pkg::RES_FINE) ? 20'(s_reg.rate)
           : 20'(20'(s_reg.rate) * term_decode_pkg::COARSE_MUL);
      up = |hit_up;
      dn = |hit_down;
      if (up ^ dn) begin
        ph = s_reg.phase + 28'(step);
        if (ph >= CLK_HZ) begin
          ph = ph - CLK_HZ;
          if (up && s_reg.freq < term_decode_pkg::FREQ_MAX)
            s_next.freq = s_reg.freq + 20'h00001;
          else if (dn && s_reg.freq != '0)
            s_next.freq = s_reg.freq - 20'h00001;
        end
        s_next.phase = ph;
      end else begin
        s_next.phase = '0;
      end

      // analog sample capture
      if (ain_valid_i) begin
        s_next.ain[0] = s_reg.cur_mode[0] ? {1'b0, ain0_i[10:1]} : ain0_i;
        s_next.ain[1] = s_reg.cur_mode[1] ? {1'b0, ain1_i[10:1]} : ain1_i;
      end

      // curve mapping and filtering, both channels alike
      for (int c = 0; c < 2; c++) begin
        if (s_reg.ain[c] < 11'(s_reg.xmin[c])) begin
          target = 17'(signed'(s_reg.sbelow[c]));
        end else if (s_reg.ain[c] >= 11'(s_reg.xmax[c])) begin
          target = 17'(signed'(s_reg.smax[c]));
        end else begin
          dspan  = 17'(signed'(s_reg.smax[c])) -
                   17'(signed'(s_reg.smin[c]));
          xoff   = signed'({1'b0, s_reg.ain[c]}) -
                   signed'({2'b00, s_reg.xmin[c]});
          xspan  = signed'({2'b00, s_reg.xmax[c]}) -
                   signed'({2'b00, s_reg.xmin[c]});
          prod   = 30'(dspan * xoff) / 30'(xspan);
          target = 17'(signed'(s_reg.smin[c])) + 17'(prod);
        end
        if (s_reg.ms_tick) begin
          tms  = 15'(s_reg.afilt[c] * term_decode_pkg::AFILT_MS);
          diff = target - 17'(signed'(s_reg.aset[c]));
          if (tms == '0) begin
            dstep = diff;
          end else begin
            dstep = diff / 17'(tms);
            if (dstep == '0 && diff != '0)
              dstep = diff[16] ? -17'sd1 : 17'sd1;
          end
          s_next.aset[c] = 16'(17'(signed'(s_reg.aset[c])) + dstep);
        end
      end

      // register writes
      if (wr_i) begin
        case (addr_i)
          term_decode_pkg::ADDR_DFILT:
            s_next.dfilt = (wdata_i > 16'(term_decode_pkg::DFILT_MAX))
                         ? term_decode_pkg::DFILT_MAX : wdata_i[9:0];
          term_decode_pkg::ADDR_SCHEME: s_next.scheme = wdata_i[1:0];
          term_decode_pkg::ADDR_RATE:   s_next.rate   = wdata_i;
          term_decode_pkg::ADDR_RES:    s_next.res    = wdata_i[1:0];
          term_decode_pkg::ADDR_CTRL:   s_next.cur_mode = wdata_i[1:0];
          default: begin
          end
        endcase
        for (int c = 0; c < 2; c++) begin
          if (bank == term_decode_pkg::CH_BANK0 + 3'(c)) begin
            case (ofs)
              term_decode_pkg::OFS_XMIN:
                s_next.xmin[c] = (wdata_i > 16'(s_reg.xmax[c]))
                               ? s_reg.xmax[c] : wdata_i[9:0];
              term_decode_pkg::OFS_XMAX:
                s_next.xmax[c] = (wdata_i > 16'(term_decode_pkg::XFULL))
                               ? term_decode_pkg::XFULL
                               : (wdata_i[9:0] < s_reg.xmin[c])
                               ? s_reg.xmin[c] : wdata_i[9:0];
              term_decode_pkg::OFS_SMIN:   s_next.smin[c] = clamp_set(wdata_i);
              term_decode_pkg::OFS_SMAX:   s_next.smax[c] = clamp_set(wdata_i);
              term_decode_pkg::OFS_SBELOW:
                s_next.sbelow[c] = clamp_set(wdata_i);
              term_decode_pkg::OFS_AFILT:
                s_next.afilt[c] = (wdata_i > 16'(term_decode_pkg::AFILT_MAX))
                                ? term_decode_pkg::AFILT_MAX : wdata_i[9:0];
              default: begin
              end
            endcase
          end
        end
        for (int i = 0; i < N_IN; i++) begin
          if (addr_i == {term_decode_pkg::FCODE_BANK, 4'(i)})
            s_next.fcode[i] = wdata_i[5:0];
        end
      end

      // register reads, data one cycle later, zero when unmapped
      s_next.rdata = '0;
      if (rd_i) begin
        case (addr_i)
          term_decode_pkg::ADDR_DFILT:   s_next.rdata = 16'(s_reg.dfilt);
          term_decode_pkg::ADDR_SCHEME:  s_next.rdata = 16'(s_reg.scheme);
          term_decode_pkg::ADDR_RATE:    s_next.rdata = s_reg.rate;
          term_decode_pkg::ADDR_RES:     s_next.rdata = 16'(s_reg.res);
          term_decode_pkg::ADDR_CTRL:    s_next.rdata = 16'(s_reg.cur_mode);
          term_decode_pkg::ADDR_STATUS: begin
            s_next.rdata[term_decode_pkg::ST_RUN]       = s_reg.run;
            s_next.rdata[term_decode_pkg::ST_REV]       = s_reg.reverse_run_request;
            s_next.rdata[term_decode_pkg::ST_MSEL +: 2] = s_reg.msel;
            s_next.rdata[term_decode_pkg::ST_DIN +: 8]  = 8'(s_reg.filt);
          end
          term_decode_pkg::ADDR_FREQ_LO: s_next.rdata = s_reg.freq[15:0];
          term_decode_pkg::ADDR_FREQ_HI: s_next.rdata = 16'(s_reg.freq[19:16]);
          default: begin
          end
        endcase
        for (int c = 0; c < 2; c++) begin
          if (bank == term_decode_pkg::CH_BANK0 + 3'(c)) begin
            case (ofs)
              term_decode_pkg::OFS_XMIN:   s_next.rdata = 16'(s_reg.xmin[c]);
              term_decode_pkg::OFS_XMAX:   s_next.rdata = 16'(s_reg.xmax[c]);
              term_decode_pkg::OFS_SMIN:   s_next.rdata = s_reg.smin[c];
              term_decode_pkg::OFS_SMAX:   s_next.rdata = s_reg.smax[c];
              term_decode_pkg::OFS_SBELOW: s_next.rdata = s_reg.sbelow[c];
              term_decode_pkg::OFS_AFILT:  s_next.rdata = 16'(s_reg.afilt[c]);
              term_decode_pkg::OFS_ASET:   s_next.rdata = s_reg.aset[c];
              default: begin
              end
            endcase
          end
        end
        for (int i = 0; i < N_IN; i++) begin
          if (addr_i == {term_decode_pkg::FCODE_BANK, 4'(i)})
            s_next.rdata = 16'(s_reg.fcode[i]);
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i || ce_i)
      s_reg <= s_next;
  end

  assign rdata_o       = s_reg.rdata;
  assign run_o         = s_reg.run;
  assign reverse_o     = s_reg.reverse_run_request;
  assign motor_sel_o   = s_reg.msel;
  assign freq_ref_o    = s_reg.freq;
  assign analog_set0_o = s_reg.aset[0];
  assign analog_set1_o = s_reg.aset[1];
  assign din_filt_o    = s_reg.filt;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  a_motor_select: assert property (
    ce_i |=> motor_sel_o == $past(sel_bits))
    else $error("motor select does not follow select terminals");
  a_two_line_fwd: assert property (
    ce_i && s_reg.scheme == 2'h0 && s_reg.filt[0] && !s_reg.filt[1]
    |=> run_o && !reverse_o)
    else $error("two-line forward not decoded");
  a_two_line_both: assert property (
    ce_i && s_reg.scheme == 2'h0 && (s_reg.filt[0] == s_reg.filt[1])
    |=> !run_o)
    else $error("two-line both or neither does not stop");
  a_run_enable_dir: assert property (
    ce_i && s_reg.scheme == 2'h1
    |=> run_o == $past(s_reg.filt[0]) && reverse_o == $past(s_reg.filt[1]))
    else $error("run enable mode mismatch");
  a_three_stop: assert property (
    ce_i && s_reg.scheme[1] && !s_reg.filt[2] |=> !run_o)
    else $error("three-line enable low did not stop");
  a_three_fwd: assert property (
    ce_i && s_reg.scheme == 2'h2 && s_reg.filt[2] && rise[0]
    |=> run_o && !reverse_o)
    else $error("three-line forward press lost");
  a_three_latch: assert property (
    ce_i && s_reg.scheme[1] && s_reg.filt[2] && run_o && rise[1:0] == 2'b00
    ##1 ce_i && s_reg.filt[2] && $stable(s_reg.scheme) |-> run_o)
    else $error("latched run dropped");
  a_three_dir: assert property (
    ce_i && s_reg.scheme == 2'h3 |=> reverse_o == $past(s_reg.filt[1]))
    else $error("three-line mode 2 direction wrong");
  a_curve_order: assert property (
    s_reg.xmin[0] <= s_reg.xmax[0] && s_reg.xmin[1] <= s_reg.xmax[1])
    else $error("curve minimum above maximum");
  a_filter_hold: assert property (
    ce_i && s_reg.sync2[0] != s_reg.filt[0] && s_reg.cnt[0] < s_reg.dfilt
    |=> $stable(s_reg.filt[0]))
    else $error("terminal passed before filter time");
  a_freq_step: assert property (
    ce_i && !(|hit_up) && !(|hit_down) |=> $stable(freq_ref_o))
    else $error("frequency moved without up or down");

  c_fwd_run: cover property (ce_i && s_reg.scheme == 2'h0 && run_o);
  c_three_rev: cover property (s_reg.scheme == 2'h2 && run_o && reverse_o);
  c_freq_up: cover property (ce_i && freq_ref_o != '0);
  c_motor4: cover property (motor_sel_o == 2'h3);

endmodule

// File: term_decode_pkg.sv
// constants for the drive terminal input decoder: register map, resets,
// function codes and timing; shared by the design and its testbench
package term_decode_pkg;

  // timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int MS_NS         = 1000000;
  localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

  // register word addresses
  localparam logic [5:0] ADDR_DFILT   = 6'h00;
  localparam logic [5:0] ADDR_SCHEME  = 6'h01;
  localparam logic [5:0] ADDR_RATE    = 6'h02;
  localparam logic [5:0] ADDR_RES     = 6'h03;
  localparam logic [5:0] ADDR_CTRL    = 6'h04;
  localparam logic [5:0] ADDR_STATUS  = 6'h05;
  localparam logic [5:0] ADDR_FREQ_LO = 6'h06;
  localparam logic [5:0] ADDR_FREQ_HI = 6'h07;
  localparam logic [2:0] CH_BANK0     = 3'h1;
  localparam logic [2:0] OFS_XMIN     = 3'h0;
  localparam logic [2:0] OFS_SMIN     = 3'h1;
  localparam logic [2:0] OFS_XMAX     = 3'h2;
  localparam logic [2:0] OFS_SMAX     = 3'h3;
  localparam logic [2:0] OFS_AFILT    = 3'h4;
  localparam logic [2:0] OFS_SBELOW   = 3'h5;
  localparam logic [2:0] OFS_ASET     = 3'h6;
  localparam logic [1:0] FCODE_BANK   = 2'h2;

  // field positions in the status word
  localparam int ST_RUN  = 0;
  localparam int ST_REV  = 1;
  localparam int ST_MSEL = 2;
  localparam int ST_DIN  = 8;

  // reset values and limits
  localparam logic [9:0]  DFILT_RST   = 10'h00a;
  localparam logic [9:0]  DFILT_MAX   = 10'h3e8;
  localparam logic [1:0]  SCHEME_RST  = 2'h0;
  localparam logic [15:0] RATE_RST    = 16'h0064;
  localparam logic [1:0]  RES_RST     = 2'h1;
  localparam logic [1:0]  RES_FINE    = 2'h2;
  localparam logic [9:0]  XMIN_RST    = 10'h000;
  localparam logic [9:0]  XMAX_RST    = 10'h3e8;
  localparam logic [9:0]  XFULL       = 10'h3e8;
  localparam logic [15:0] SMIN_RST    = 16'h0000;
  localparam logic [15:0] SMAX_RST    = 16'h2710;
  localparam logic [15:0] SBELOW_RST  = 16'h0000;
  localparam logic [15:0] SET_POS_MAX = 16'h2710;
  localparam logic [15:0] SET_NEG_MAX = 16'hd8f0;
  localparam logic [9:0]  AFILT_RST   = 10'h00a;
  localparam logic [9:0]  AFILT_MAX   = 10'h3e8;
  localparam logic [3:0]  AFILT_MS    = 4'ha;
  localparam logic [19:0] COARSE_MUL  = 20'h0000a;
  localparam logic [19:0] FREQ_MAX    = 20'h0c350;

  // terminal function codes
  localparam logic [5:0] FN_UP    = 6'h06;
  localparam logic [5:0] FN_DOWN  = 6'h07;
  localparam logic [5:0] FN_MSEL1 = 6'h29;
  localparam logic [5:0] FN_MSEL2 = 6'h2a;

endpackage

// File: term_switch_model.sv
// switches, push buttons and analog sources wired to the terminal decoder
// assumes the bench sets wanted levels on rising edges of clk_i
`timescale 1ns/1ns

module term_switch_model (
  // clock
  input  wire logic        clk_i,
  // wanted levels from the bench
  input  wire logic [7:0]  sw_i,
  input  wire logic [10:0] volt0_i,
  input  wire logic [10:0] volt1_i,
  input  wire logic [1:0]  cur_i,
  // terminal side
  output logic      [7:0]  din_o = 8'h00,
  output logic      [10:0] ain0_o,
  output logic      [10:0] ain1_o,
  output logic             ain_valid_o = 1'b0
);
  logic [1:0] phase_reg = 2'h0;

  // contacts follow one cycle late; the bench holds them past the filter except in the glitch test
  always_ff @(posedge clk_i) begin
    din_o       <= sw_i;
    phase_reg   <= phase_reg + 2'h1;
    ain_valid_o <= (phase_reg == 2'h3);
  end

  // a current source gives 1 mA for each 0.5 V of wanted level
  assign ain0_o = cur_i[0] ? {volt0_i[9:0], 1'b0} : volt0_i;
  assign ain1_o = cur_i[1] ? {volt1_i[9:0], 1'b0} : volt1_i;
endmodule
